// *** rtl/serial_unit_pkg.sv ***
// constants, register map and types for the clocked serial transmit units
// assumes one 25 MHz clock and an AXI4-Lite master with byte addresses
package serial_unit_pkg;
	localparam int          NUNIT          = 2;        // serial units, one channel each
	localparam int          ADDR_W         = 8;        // byte address width
	localparam int          GATE_BIT0      = 2;        // clock gate of unit 0, unit 1 next bit up
	// byte offsets
	localparam logic [7:0]  OFF_CLOCK_GATE = 8'h00;    // peripheral_clock_gate
	localparam logic [1:0]  UNIT0_SEL      = 2'b01;    // unit 0 window at 0x40
	localparam logic [1:0]  UNIT1_SEL      = 2'b10;    // unit 1 window at 0x80
	localparam logic [5:0]  ROFF_PRESCALE  = 6'h00;    // prescaler_setup_reg
	localparam logic [5:0]  ROFF_MODE      = 6'h04;    // channel_mode_setup
	localparam logic [5:0]  ROFF_COMM      = 6'h08;    // channel_comm_setup
	localparam logic [5:0]  ROFF_DATA      = 6'h0C;    // channel_data_and_divider
	localparam logic [5:0]  ROFF_START     = 6'h10;    // channel start trigger
	localparam logic [5:0]  ROFF_STOP      = 6'h14;    // channel_stop_trigger_reg
	localparam logic [5:0]  ROFF_ENABLE    = 6'h18;    // channel_enable_status_reg
	localparam logic [5:0]  ROFF_OUT_EN    = 6'h1C;    // output_enable_reg
	localparam logic [5:0]  ROFF_LEVELS    = 6'h20;    // unit_output_levels
	localparam logic [5:0]  ROFF_XSTAT     = 6'h24;    // transfer status
	localparam logic [5:0]  ROFF_RXDATA    = 6'h28;    // low-power receive byte
	// field positions
	localparam int          MODE_OPCLK_BIT = 15;       // op_clock_select
	localparam int          MODE_LPRX_BIT  = 1;        // low-power reception enable
	localparam int          MODE_IRQ_BIT   = 0;        // interrupt_source_select
	localparam int          COMM_DAP_BIT   = 13;       // data_phase_select
	localparam int          COMM_CKP_BIT   = 12;       // clock_phase_select
	localparam int          COMM_ORDER_BIT = 7;        // bit_order_select
	localparam int          COMM_LEN_BIT   = 0;        // frame_length_select
	localparam int          DIV_LSB        = 9;        // divider field [15:9]
	localparam int          LVL_CLK_BIT    = 8;        // clock_output_level
	localparam int          LVL_DATA_BIT   = 0;        // data_output_level
	// reset values
	localparam logic [7:0]  GATE_RST       = 8'h00;
	localparam logic [7:0]  PRESCALE_RST   = 8'h00;
	localparam logic [15:0] MODE_RST       = 16'h0000;
	localparam logic [15:0] COMM_RST       = 16'h0001;
	localparam logic [15:0] DATA_RST       = 16'h0000;
	localparam logic [15:0] LEVELS_RST     = 16'h0101;
	// shortest half period of the serial clock, in system clocks
	localparam logic [1:0]  MIN_HALF_U0    = 2'h1;     // fclk/2
	localparam logic [1:0]  MIN_HALF_U1    = 2'h2;     // fclk/4
	localparam logic [3:0]  LAST_HALF_8    = 4'hF;     // 16 half periods
	localparam logic [3:0]  LAST_HALF_7    = 4'hD;     // 14 half periods
	localparam logic [2:0]  RX_LAST_BIT    = 3'h7;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,                          // waiting for a buffered byte
		ST_LEAD  = 2'b01,                          // half period of early data
		ST_SHIFT = 2'b10                           // clock toggling
	} tx_state_t;
endpackage : serial_unit_pkg

// *** rtl/unit_prescaler.sv ***
// two power-of-two tick enables for one serial unit
// assumes run is low whenever the unit clock gate is off
`timescale 1ns/1ps
module unit_prescaler
	import serial_unit_pkg::*;
(
	input  wire logic       aclk,      // system clock
	input  wire logic       aresetn,   // synchronous reset, low active
	input  wire logic       run,       // unit clock supplied
	input  wire logic [3:0] sel0,      // exponent of prescaler_clock_zero
	input  wire logic [3:0] sel1,      // exponent of prescaler_clock_one
	output logic            tick0_q,   // one-cycle enable, clock zero
	output logic            tick1_q    // one-cycle enable, clock one
);
	logic [14:0] cnt_q;                // free count while running

	// ones in the low k bits
	function automatic logic [14:0] low_mask(input logic [3:0] k);
		low_mask = 15'((16'h0001 << k) - 16'h0001);
	endfunction : low_mask

	// counter stops with the gate, so a gated unit draws no ticks
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q   <= '0;
			tick0_q <= 1'b0;
			tick1_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_q + 15'h0001;
			tick0_q <= (cnt_q & low_mask(sel0)) == low_mask(sel0);
			tick1_q <= (cnt_q & low_mask(sel1)) == low_mask(sel1);
		end
	end
endmodule : unit_prescaler

// *** rtl/serial_array_tx.sv ***
// two clocked serial transmit units with clock gate, stop controls and AXI4-Lite registers
// assumes synchronous pin inputs and an AXI4-Lite master on aclk
//
// Notes on behaviour
// RULE1 - gate bits 2 and 3 stop units
// RULE2 - gate 0 stops unit clock, 1 runs
// RULE3 - gated unit ignores writes, reads defaults
// RULE4 - software keeps unused gate bits zero
// RULE5 - stop bit triggers, clears when status zero
// RULE6 - enable status read-only, cleared by stop
// RULE7 - stopped channel clock pin follows level bit
// RULE8 - output disable lets data level bit drive
// RULE9 - port use needs both levels high; port_mode here follows only the stopped status, not the level bits
// RULE10 - stopped channel shifts nothing, pins free
// RULE11 - master makes clock, shifts data out
// RULE12 - length bit: 0 seven, 1 eight
// RULE13 - order bit: 0 msb first, 1 lsb
// RULE14 - phase bit 1 leads data half period
// RULE15 - clock phase bit inverts clock
// RULE16 - source bit: end or buffer empty event
// RULE17 - op clock from prescaler zero or one
// RULE18 - prescaler then divider; data low byte
// RULE19 - unit0 max fclk/2, others fclk/4
// RULE20 - peer clock below op clock sixth
// RULE21 - unit0 receives on clock while stopped
// RULE22 - stopped or disabled pins hold levels
`timescale 1ns/1ps
module serial_array_tx
	import serial_unit_pkg::*;
(
	input  wire logic              aclk,            // system clock, 25 MHz
	input  wire logic              aresetn,         // synchronous reset, low active
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
	input  wire logic              s_axi_awvalid,   // write address valid
	output logic                   s_axi_awready,   // write address ready
	input  wire logic [31:0]       s_axi_wdata,     // write data
	input  wire logic [3:0]        s_axi_wstrb,     // write byte strobes
	input  wire logic              s_axi_wvalid,    // write data valid
	output logic                   s_axi_wready,    // write data ready
	output logic [1:0]             s_axi_bresp,     // write response
	output logic                   s_axi_bvalid,    // write response valid
	input  wire logic              s_axi_bready,    // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
	input  wire logic              s_axi_arvalid,   // read address valid
	output logic                   s_axi_arready,   // read address ready
	output logic [31:0]            s_axi_rdata,     // read data
	output logic [1:0]             s_axi_rresp,     // read response
	output logic                   s_axi_rvalid,    // read data valid
	input  wire logic              s_axi_rready,    // read data ready
	input  wire logic              lp_sck_in,       // unit 0 serial clock in, low-power receive
	input  wire logic              lp_sdi_in,       // unit 0 serial data in, low-power receive
	output logic [NUNIT-1:0]       sck_out,         // serial clock pins
	output logic [NUNIT-1:0]       sdo_out,         // serial data pins
	output logic [NUNIT-1:0]       port_mode,       // pins free for port use
	output logic [NUNIT-1:0]       csi_channel_irq  // channel event pulse
);
	// bus side state
	logic              aw_held_q;                    // write address captured
	logic              w_held_q;                     // write data captured
	logic [ADDR_W-1:0] awaddr_q;                     // captured write address
	logic [31:0]       wdata_q;                      // captured write data
	logic [3:0]        wstrb_q;                      // captured strobes
	logic              wr_go;                        // both halves present
	logic              wr_ok;                        // write address mapped
	logic [31:0]       rd_word;                      // read mux result
	// register file
	logic [7:0]        gate_q;                       // peripheral_clock_gate
	logic [7:0]        psc_q   [NUNIT];              // prescaler exponents
	logic [15:0]       mode_q  [NUNIT];              // channel_mode_setup
	logic [15:0]       comm_q  [NUNIT];              // channel_comm_setup
	logic [15:0]       data_q  [NUNIT];              // channel_data_and_divider
	logic [15:0]       lvl_q   [NUNIT];              // unit_output_levels
	logic [NUNIT-1:0]  oe_q;                         // channel_output_enable
	logic [NUNIT-1:0]  unit_on;                      // unit clock supplied
	logic [NUNIT-1:0]  wr_unit;                      // accepted write to unit
	logic [NUNIT-1:0]  wr_data, wr_start, wr_stop;   // write side effects
	// channel engine state
	tx_state_t         st_q    [NUNIT];              // shifter state
	logic [NUNIT-1:0]  en_q;                         // channel_enable_status
	logic [NUNIT-1:0]  stop_q;                       // channel_stop_trigger
	logic [NUNIT-1:0]  bfull_q;                      // byte waiting in buffer
	logic [NUNIT-1:0]  dout_q;                       // bit on the data line
	logic [7:0]        shift_q [NUNIT];              // byte being sent
	logic [3:0]        hc_q    [NUNIT];              // half period index
	logic [6:0]        dcnt_q  [NUNIT];              // divider count
	logic [1:0]        gap_q   [NUNIT];              // clocks since last half
	logic [NUNIT-1:0]  tick0, tick1;                 // prescaler enables
	logic [NUNIT-1:0]  half;                         // half period boundary
	// low-power receiver, unit 0
	logic              lp_sck_prev_q;                // previous clock level
	logic [7:0]        lp_sr_q;                      // receive shifter
	logic [2:0]        lp_cnt_q;                     // bits received
	logic [7:0]        lp_rx_q;                      // last received byte
	logic              lp_done_q;                    // byte received pulse

	// register word reachable at this address
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a == OFF_CLOCK_GATE) ||
		          ((a[7:6] == UNIT0_SEL || a[7:6] == UNIT1_SEL) &&
		           a[5:0] <= ROFF_RXDATA && a[1:0] == 2'b00);
	endfunction : addr_ok

	// unit index of an address in a unit window
	function automatic logic unit_of(input logic [ADDR_W-1:0] a);
		unit_of = (a[7:6] == UNIT1_SEL);
	endfunction : unit_of

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
	                                        input logic [3:0] sb);
		merge16 = {sb[1] ? wd[15:8] : old[15:8], sb[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// frame bit at position idx, honouring order and length
	function automatic logic frame_bit(input logic [7:0] d, input logic [2:0] idx,
	                                   input logic lsb_first, input logic len8);
		if (lsb_first)
			frame_bit = d[idx];                                        // [RULE13]
		else if (len8)
			frame_bit = d[3'h7 - idx];                                 // [RULE12]
		else
			frame_bit = d[3'h6 - idx];
	endfunction : frame_bit

	// write decode, shared by every write-side process
	always_comb begin
		wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
		wr_ok = addr_ok(awaddr_q);
		for (int u = 0; u < NUNIT; u++) begin
			unit_on[u]  = gate_q[GATE_BIT0 + u];                        // [RULE1] [RULE2]
			// a gated unit drops the write silently
			wr_unit[u]  = wr_go && wr_ok && awaddr_q != OFF_CLOCK_GATE &&
			              unit_of(awaddr_q) == u[0] && unit_on[u];      // [RULE3]
			wr_data[u]  = wr_unit[u] && awaddr_q[5:0] == ROFF_DATA;
			wr_start[u] = wr_unit[u] && awaddr_q[5:0] == ROFF_START && wstrb_q[0] && wdata_q[0];
			wr_stop[u]  = wr_unit[u] && awaddr_q[5:0] == ROFF_STOP && wstrb_q[0] && wdata_q[0];
		end
	end

	// write address and data channels, accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				// unmapped address answers slave error
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// clock gate register, never itself gated
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gate_q <= GATE_RST;
		else if (wr_go && wr_ok && awaddr_q == OFF_CLOCK_GATE && wstrb_q[0])
			gate_q <= wdata_q[7:0];
	end

	// setup registers; a gated unit is held at reset values
	always_ff @(posedge aclk) begin
		for (int u = 0; u < NUNIT; u++) begin
			if (!aresetn || !unit_on[u]) begin                      // [RULE3]
				psc_q[u]  <= PRESCALE_RST;
				mode_q[u] <= MODE_RST;
				comm_q[u] <= COMM_RST;
				data_q[u] <= DATA_RST;
				lvl_q[u]  <= LEVELS_RST;
				oe_q[u]   <= 1'b0;
			end else if (wr_unit[u]) begin
				case (awaddr_q[5:0])
					ROFF_PRESCALE: if (wstrb_q[0]) psc_q[u] <= wdata_q[7:0];
					ROFF_MODE:     mode_q[u] <= merge16(mode_q[u], wdata_q, wstrb_q);
					ROFF_COMM:     comm_q[u] <= merge16(comm_q[u], wdata_q, wstrb_q);
					ROFF_DATA:     data_q[u] <= merge16(data_q[u], wdata_q, wstrb_q); // [RULE18]
					ROFF_OUT_EN:   if (wstrb_q[0]) oe_q[u] <= wdata_q[0];          // [RULE8]
					ROFF_LEVELS:   lvl_q[u] <= merge16(lvl_q[u], wdata_q, wstrb_q);  // [RULE7]
					default:       ;                                // triggers and read-only words
				endcase
			end
		end
	end

	// per-unit prescalers
	for (genvar g = 0; g < NUNIT; g++) begin : g_psc
		unit_prescaler u_psc (
			.aclk    (aclk),
			.aresetn (aresetn),
			.run     (unit_on[g]),                                     // [RULE2]
			.sel0    (psc_q[g][3:0]),
			.sel1    (psc_q[g][7:4]),
			.tick0_q (tick0[g]),
			.tick1_q (tick1[g])
		);
	end

	// half period boundary: op clock, divider, then the rate floor
	always_comb begin
		for (int u = 0; u < NUNIT; u++) begin
			half[u] = (mode_q[u][MODE_OPCLK_BIT] ? tick1[u] : tick0[u]) &&   // [RULE17]
			          dcnt_q[u] == data_q[u][15:DIV_LSB] &&                    // [RULE18]
			          gap_q[u] >= ((u == 0) ? MIN_HALF_U0 : MIN_HALF_U1) - 2'h1; // [RULE19]
		end
	end

	// channel engine: triggers, buffer, shifter and pins
	always_ff @(posedge aclk) begin
		for (int u = 0; u < NUNIT; u++) begin
			logic       len8, dap, lsb;
			logic [3:0] nh;
			logic [3:0] nxt;
			len8 = comm_q[u][COMM_LEN_BIT];
			dap  = comm_q[u][COMM_DAP_BIT];
			lsb  = comm_q[u][COMM_ORDER_BIT];
			nh   = hc_q[u] + 4'h1;
			nxt  = {1'b0, nh[3:1]} + 4'h1;
			if (!aresetn || !unit_on[u]) begin
				st_q[u]    <= ST_IDLE;
				en_q[u]    <= 1'b0;
				stop_q[u]  <= 1'b0;
				bfull_q[u] <= 1'b0;
				dout_q[u]  <= 1'b0;
				shift_q[u] <= '0;
				hc_q[u]    <= '0;
				dcnt_q[u]  <= '0;
				gap_q[u]   <= '0;
				sck_out[u] <= LEVELS_RST[LVL_CLK_BIT];
				sdo_out[u] <= LEVELS_RST[LVL_DATA_BIT];
				port_mode[u]       <= 1'b1;
				csi_channel_irq[u] <= 1'b0;
			end else begin
				csi_channel_irq[u] <= 1'b0;
				// trigger reads back 1 until status has dropped
				stop_q[u] <= wr_stop[u] || (stop_q[u] && en_q[u]);      // [RULE5]
				if (stop_q[u])
					en_q[u] <= 1'b0;                                     // [RULE6]
				else if (wr_start[u])
					en_q[u] <= 1'b1;
				// a new byte overwrites an unsent one
				if (wr_data[u] && en_q[u])
					bfull_q[u] <= 1'b1;
				// divider and floor counters run only during a frame
				if (st_q[u] == ST_IDLE || half[u]) begin
					dcnt_q[u] <= '0;
					gap_q[u]  <= '0;
				end else begin
					if ((mode_q[u][MODE_OPCLK_BIT] ? tick1[u] : tick0[u]) &&
					    dcnt_q[u] != data_q[u][15:DIV_LSB])
						dcnt_q[u] <= dcnt_q[u] + 7'h01;
					if (gap_q[u] != 2'h3)
						gap_q[u] <= gap_q[u] + 2'h1;
				end
				if (!en_q[u] || stop_q[u]) begin
					st_q[u]    <= ST_IDLE;                               // [RULE10]
					bfull_q[u] <= 1'b0;
				end else begin
					case (st_q[u])
						ST_IDLE: begin
							if (bfull_q[u] && !wr_data[u]) begin         // [RULE11]
								shift_q[u] <= data_q[u][7:0];
								bfull_q[u] <= 1'b0;
								hc_q[u]    <= '0;
								dout_q[u]  <= frame_bit(data_q[u][7:0], 3'h0, lsb, len8);
								// buffer empty event in continuous mode
								csi_channel_irq[u] <= mode_q[u][MODE_IRQ_BIT];    // [RULE16]
								st_q[u]    <= dap ? ST_LEAD : ST_SHIFT;  // [RULE14]
							end
						end
						ST_LEAD: begin
							if (half[u])
								st_q[u] <= ST_SHIFT;
						end
						ST_SHIFT: begin
							if (half[u]) begin
								if (hc_q[u] == (len8 ? LAST_HALF_8 : LAST_HALF_7)) begin // [RULE12]
									// transfer end event in single mode
									csi_channel_irq[u] <= !mode_q[u][MODE_IRQ_BIT]; // [RULE16]
									st_q[u] <= ST_IDLE;
								end else begin
									hc_q[u] <= nh;
									// phase 0 changes data as clock falls, phase 1 as it rises
									if (!dap && !nh[0])
										dout_q[u] <= frame_bit(shift_q[u], nh[3:1], lsb, len8);
									else if (dap && nh[0] && nxt < (len8 ? 4'h8 : 4'h7))
										dout_q[u] <= frame_bit(shift_q[u], nxt[2:0], lsb, len8); // [RULE14]
								end
							end
						end
						default: st_q[u] <= ST_IDLE;
					endcase
				end
				// pins come from flops so level changes cannot glitch
				if (en_q[u] && st_q[u] == ST_SHIFT)
					sck_out[u] <= hc_q[u][0] ^ comm_q[u][COMM_CKP_BIT];  // [RULE15]
				else
					sck_out[u] <= lvl_q[u][LVL_CLK_BIT];                 // [RULE7] [RULE22]
				if (en_q[u] && oe_q[u])
					sdo_out[u] <= dout_q[u];
				else
					sdo_out[u] <= lvl_q[u][LVL_DATA_BIT];                // [RULE8] [RULE22]
				port_mode[u] <= !en_q[u];                                 // [RULE10]
				// unit 0 also reports a byte taken in low-power receive
				if (u == 0 && lp_done_q)
					csi_channel_irq[u] <= 1'b1;                          // [RULE21]
			end
		end
	end

	// low-power receive on unit 0 while its channel is stopped
	always_ff @(posedge aclk) begin
		if (!aresetn || !unit_on[0] || en_q[0] || !mode_q[0][MODE_LPRX_BIT]) begin
			lp_sck_prev_q <= 1'b1;
			lp_sr_q       <= '0;
			lp_cnt_q      <= '0;
			lp_done_q     <= 1'b0;
			if (!aresetn || !unit_on[0])
				lp_rx_q <= '0;
		end else begin
			lp_sck_prev_q <= lp_sck_in;
			lp_done_q     <= 1'b0;
			// sample on the rising edge of the peer clock
			if (lp_sck_in && !lp_sck_prev_q) begin                     // [RULE21]
				lp_sr_q  <= comm_q[0][COMM_ORDER_BIT] ? {lp_sdi_in, lp_sr_q[7:1]}
				                                      : {lp_sr_q[6:0], lp_sdi_in};
				lp_cnt_q <= lp_cnt_q + 3'h1;
				if (lp_cnt_q == RX_LAST_BIT) begin
					lp_rx_q   <= comm_q[0][COMM_ORDER_BIT] ? {lp_sdi_in, lp_sr_q[7:1]}
					                                       : {lp_sr_q[6:0], lp_sdi_in};
					lp_done_q <= 1'b1;
				end
			end
		end
	end

	// read mux; a gated unit shows its reset values
	always_comb begin
		logic r;
		r       = unit_of(s_axi_araddr);
		rd_word = '0;
		if (s_axi_araddr == OFF_CLOCK_GATE)
			rd_word[7:0] = gate_q;
		else begin
			case (s_axi_araddr[5:0])
				ROFF_PRESCALE: rd_word[7:0]  = psc_q[r];
				ROFF_MODE:     rd_word[15:0] = mode_q[r];
				ROFF_COMM:     rd_word[15:0] = comm_q[r];
				ROFF_DATA:     rd_word[15:0] = data_q[r];
				ROFF_STOP:     rd_word[0]    = stop_q[r];
				ROFF_ENABLE:   rd_word[0]    = en_q[r];                    // [RULE6]
				ROFF_OUT_EN:   rd_word[0]    = oe_q[r];
				ROFF_LEVELS:   rd_word[15:0] = lvl_q[r];
				ROFF_XSTAT:    rd_word[2:0]  = {bfull_q[r], st_q[r] != ST_IDLE, en_q[r]};
				ROFF_RXDATA:   rd_word[7:0]  = (r == 1'b0) ? lp_rx_q : 8'h00;
				default:       rd_word       = '0;
			endcase
		end
	end

	// read channel, one word at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= addr_ok(s_axi_araddr) ? rd_word : 32'h0000_0000;
			s_axi_rresp   <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : serial_array_tx

// *** sim/serial_array_tx_chk.sv ***
// checker: bus answers and pin timing of the serial units
// assumes a bind onto serial_array_tx
`timescale 1ns/1ps
module serial_array_tx_chk import serial_unit_pkg::*; (
	input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [NUNIT-1:0] sck_out, sdo_out, port_mode, csi_channel_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write not answered");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	// idle unit 0 pins only move after a register write lands
	a_stop_pins_hold: assert property ((port_mode[0] && !s_axi_bvalid) [*2] |-> $stable(sck_out[0]) && $stable(sdo_out[0]))
		else $error("stopped pins moved");
	a_irq_one_cycle: assert property (csi_channel_irq[0] |=> !csi_channel_irq[0])
		else $error("event longer than a cycle");
	a_irq_when_run: assert property (csi_channel_irq[1] |-> !port_mode[1])
		else $error("event on stopped unit");
	a_unit1_half_min: assert property ($changed(sck_out[1]) && !port_mode[1] && !$past(port_mode[1]) |=> $stable(sck_out[1]))
		else $error("unit one clock too fast");
	cover property (csi_channel_irq[0]);
	cover property (csi_channel_irq[1]);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule : serial_array_tx_chk
bind serial_array_tx serial_array_tx_chk serial_array_tx_chk_inst (.*);

// *** sim/serial_peer_model.sv ***
// serial peer: receiving end of the selected serial unit
// assumes clock phase 0, data taken on the rising serial clock
`timescale 1ns/1ps
module serial_peer_model (
	input wire logic [1:0] sck, sdo, run, // pins and running flags
	input wire logic       sel, clr,      // unit watched, count clear
	output logic [7:0]     got,           // bits in arrival order
	output int             cnt            // bits taken
);
	wire logic s = sck[sel]; // clock of the watched unit
	// take a bit only while the unit runs
	always @(posedge s or posedge clr)
		if (clr) begin got <= '0; cnt <= 0; end
		else if (run[sel]) begin got <= {got[6:0], sdo[sel]}; cnt <= cnt + 1; end
endmodule : serial_peer_model

// *** sim/tb_serial_array_tx.sv ***
// testbench: register access and frames of both serial units
// assumes the design and peer model are compiled first
`timescale 1ns/1ps
module tb_serial_array_tx import serial_unit_pkg::*;;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, lp_sck_in = 0, lp_sdi_in = 0, clr = 1, sel = 0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, got;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, sck_out, sdo_out, port_mode, csi_channel_irq, rsp;
	int fail_count = 0, n_compared = 0, cnt;
	logic [15:0] cm [3] = '{16'h0001, 16'h0081, 16'h0000}; // 8 msb, 8 lsb, 7 msb
	logic [7:0] gb [3] = '{8'h1E, 8'h78, 8'h1E};
	int nb [3] = '{8, 8, 7};
	serial_array_tx serial_array_tx_inst (.*);
	serial_peer_model serial_peer_model_inst (.sck(sck_out), .sdo(sdo_out), .run(~port_mode), .sel(sel),
		.clr(clr), .got(got), .cnt(cnt));
	always #20 aclk = ~aclk;
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin fail_count++; $display("BAD %s exp %h seen %h", nm, exp, seen); end
	endtask : chk
	task automatic summarize;
		if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
	endtask : wr
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rsp = s_axi_rresp; s_axi_rready <= 0;
		chk(nm, s_axi_rdata, e);
	endtask : rc
	// one frame; waits for the end event, bounded; ev is whether one is due
	task automatic frame(input logic u, input logic [15:0] comm, data, input logic ev);
		int t = 0;
		clr <= 1; sel <= u;
		wr({u, ~u, ROFF_COMM}, comm);
		clr <= 0;
		wr({u, ~u, ROFF_DATA}, data);
		while (csi_channel_irq[u] !== 1'b1 && t < 400) begin @(posedge aclk); t++; end
		chk("end event", csi_channel_irq[u], ev);
		repeat (4) @(posedge aclk);
	endtask : frame
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rc("gate", OFF_CLOCK_GATE, 0);
		wr({2'b01, ROFF_LEVELS}, 0);
		rc("gated levels", {2'b01, ROFF_LEVELS}, 32'h0000_0101);
		wr(OFF_CLOCK_GATE, 32'h0000_000C);
		rc("gate", OFF_CLOCK_GATE, 32'h0000_000C);
		rc("unmapped", 8'hFC, 0);
		chk("rresp", rsp, 2'b10);
		for (int u = 0; u < 2; u++) begin
			wr({u[0], ~u[0], ROFF_START}, 1);
			wr({u[0], ~u[0], ROFF_OUT_EN}, 1);
		end
		wr({2'b01, ROFF_ENABLE}, 0);
		rc("status ro", {2'b01, ROFF_ENABLE}, 1);
		for (int i = 0; i < 3; i++) begin
			frame(0, cm[i], 16'h001E, 1);
			chk("bit count", cnt, nb[i]);
			chk("byte", got, gb[i]);
		end
		frame(1, 16'h0001, 16'h023C, 1);
		chk("divided byte", got, 8'h3C);
		frame(1, 16'h0001, 16'h005A, 1);
		chk("fast byte", got, 8'h5A);
		wr({2'b01, ROFF_STOP}, 1);
		rc("stop trigger", {2'b01, ROFF_STOP}, 0);
		rc("status", {2'b01, ROFF_ENABLE}, 0);
		wr({2'b01, ROFF_LEVELS}, 0);
		repeat (3) @(posedge aclk);
		chk("clock pin", sck_out[0], 0);
		chk("data pin", sdo_out[0], 0);
		chk("port mode", port_mode[0], 1);
		frame(0, 16'h0001, 16'h0055, 0);
		chk("stopped bits", cnt, 0);
		wr({2'b01, ROFF_MODE}, 2);
		for (int i = 7; i >= 0; i--) begin
			lp_sdi_in <= gb[1][i];
			@(posedge aclk) lp_sck_in <= 1;
			@(posedge aclk) lp_sck_in <= 0;
		end
		rc("rx byte", {2'b01, ROFF_RXDATA}, gb[1]);
		wr({2'b01, ROFF_LEVELS}, 32'h0000_0101);
		wr(OFF_CLOCK_GATE, 32'h0000_0008);
		wr({2'b01, ROFF_COMM}, 32'h0000_0081);
		rc("gated comm", {2'b01, ROFF_COMM}, 32'h0000_0001);
		summarize();
	end
	// hang guard, far beyond the several hundred cycles needed
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		summarize();
	end
endmodule : tb_serial_array_tx
